/* logic/bors_sequencer.v */
// Supply-drop reset sequencer: reset pulse, clock hold and power-up delay.
// Assumes an asynchronous comparator input and a PLL lock from another domain.
`timescale 1ns/1ps
`include "bors_defines.vh"

module bors_sequencer #(
  parameter [31:0] PWRUP_CYC = `BORS_PWRUP_CYC,
  parameter [31:0] FSCM_CYC  = `BORS_FSCM_CYC,
  parameter [31:0] STARTUP_CYC = `BORS_STARTUP_CYC
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       sys_rst_i,
  // Supply monitor and power modes
  input  wire       supply_drop_i,
  input  wire       sleep_mode_i,
  input  wire       idle_mode_i,
  // Configuration
  input  wire [2:0] osc_select_cfg_i,
  input  wire [1:0] primary_osc_mode_cfg_i,
  input  wire       pwrup_delay_en_i,
  // Clock generator status
  input  wire       pll_lock_i,
  // Software clear of status flag
  input  wire       flag_wr_i,
  input  wire       flag_wdata_i,
  // Outputs
  output reg        device_rst_o,
  output reg        internal_rst_o,
  output reg        sysclk_en_o,
  output reg [2:0]  clk_source_o,
  output reg        pll_sel_o,
  output reg [5:0]  osc_control_reg_o,
  output reg [1:0]  reset_control_reg_o
);

  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_PULSE = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_RUN   = 3'h3;

  // Source uses primary oscillator
  function is_osc;
    input [2:0] sel;
    begin
      is_osc = (sel == `BORS_OSC_PRI) || (sel == `BORS_OSC_PRI_PLL);
    end
  endfunction

  // Source uses the PLL
  function is_pll;
    input [2:0] sel;
    begin
      is_pll = (sel == `BORS_OSC_FRC_PLL) || (sel == `BORS_OSC_PRI_PLL);
    end
  endfunction

  reg  [2:0] state_reg;
  reg  [2:0] state_next;
  reg  [7:0] pulse_reg;
  reg        drop_s1_reg;
  reg        drop_s2_reg;
  reg        lock_s1_reg;
  reg        lock_s2_reg;
  reg        need_ost_reg;
  reg        need_pll_reg;
  reg        xtal_reg;
  reg        pwr_en_reg;
  wire       ost_done;
  wire       pwr_done;
  wire       start_delays;
  wire       clk_ready;
  wire       delay_ready;
  wire [31:0] pwr_count;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for comparator and lock
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      drop_s1_reg <= 1'b0;
      drop_s2_reg <= 1'b0;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end
    else
    begin
      drop_s1_reg <= supply_drop_i;
      drop_s2_reg <= drop_s1_reg;
      lock_s1_reg <= pll_lock_i;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay counters, started as the pulse ends
  assign start_delays = (state_reg == ST_PULSE) && (pulse_reg == 8'h01);

  assign pwr_count = pwr_en_reg ? PWRUP_CYC : (xtal_reg ? FSCM_CYC : 32'h0000_0000);

  bors_delay_counter #(
    .WIDTH (32)
  ) u_osc_startup_counter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (start_delays),
    .count_i   (need_ost_reg ? STARTUP_CYC : 32'h0000_0000),
    .done_o    (ost_done)
  );

  bors_delay_counter #(
    .WIDTH (32)
  ) u_powerup_delay_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (start_delays),
    .count_i   (pwr_count),
    .done_o    (pwr_done)
  );

  assign clk_ready   = ost_done && (!need_pll_reg || lock_s2_reg);
  assign delay_ready = pwr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  state_next = ST_PULSE;
      ST_PULSE:
      begin
        if (pulse_reg == 8'h01)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (clk_ready && delay_ready)
          state_next = ST_RUN;
      end
      ST_RUN:   state_next = ST_RUN;
      default:  state_next = ST_IDLE;
    endcase
    if (drop_s2_reg)
      state_next = ST_PULSE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, config capture and outputs
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg           <= ST_IDLE;
      pulse_reg           <= 8'h00;
      need_ost_reg        <= 1'b0;
      need_pll_reg        <= 1'b0;
      xtal_reg            <= 1'b0;
      pwr_en_reg          <= 1'b0;
      device_rst_o        <= 1'b1;
      internal_rst_o      <= 1'b1;
      sysclk_en_o         <= 1'b0;
      clk_source_o        <= `BORS_OSC_FRC;
      pll_sel_o           <= 1'b0;
      osc_control_reg_o   <= 6'h00;
      reset_control_reg_o <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      // pulse length
      // Pulse also runs after reset release
      if (drop_s2_reg || state_reg == ST_IDLE)
        pulse_reg <= `BORS_RST_PULSE_CYC;
      else if (pulse_reg != 8'h00)
        pulse_reg <= pulse_reg - 8'h01;
      if (drop_s2_reg || state_reg == ST_IDLE)
      begin
        clk_source_o <= osc_select_cfg_i;
        pll_sel_o    <= is_pll(osc_select_cfg_i);
        need_ost_reg <= is_osc(osc_select_cfg_i) &&
                        (primary_osc_mode_cfg_i != `BORS_POSC_OFF);
        need_pll_reg <= is_pll(osc_select_cfg_i);
        xtal_reg     <= is_osc(osc_select_cfg_i) &&
                        ((primary_osc_mode_cfg_i == `BORS_POSC_XT) ||
                         (primary_osc_mode_cfg_i == `BORS_POSC_HS));
        pwr_en_reg   <= pwrup_delay_en_i;
      end
      device_rst_o   <= (state_next == ST_PULSE) || (state_next == ST_IDLE);
      internal_rst_o <= (state_next != ST_RUN);
      // clock gated until ready
      // Only after a cycle of wait, so stale counter status cannot ungate
      sysclk_en_o    <= (state_reg == ST_WAIT || state_reg == ST_RUN) &&
                        (state_next == ST_WAIT || state_next == ST_RUN) && clk_ready;
      osc_control_reg_o <= {lock_s2_reg, 5'h00};
      // set flag; software clear, set wins
      if (drop_s2_reg)
        reset_control_reg_o[`BORS_RST_CTRL_FLAG_BIT] <= 1'b1;
      else if (flag_wr_i && !flag_wdata_i)
        reset_control_reg_o[`BORS_RST_CTRL_FLAG_BIT] <= 1'b0;
    end
  end

endmodule

/* common/bors_defines.vh */
// Constants for the supply-drop reset sequencer.
// Assumes a 50 MHz system clock; figures are plain defaults where none is given.
`ifndef BORS_DEFINES_VH
`define BORS_DEFINES_VH

// Clock period in ns
`define BORS_CLK_PERIOD_NS      20
// Reset pulse width in cycles
`define BORS_RST_PULSE_CYC      8'h08
// Power-up delay time in ns (default, parameter at top)
`define BORS_PWRUP_TIME_NS      64000000
`define BORS_PWRUP_CYC          (`BORS_PWRUP_TIME_NS / `BORS_CLK_PERIOD_NS)
// Fail-safe monitor delay in ns (default, parameter at top)
`define BORS_FSCM_TIME_NS       500000
`define BORS_FSCM_CYC           (`BORS_FSCM_TIME_NS / `BORS_CLK_PERIOD_NS)
// Oscillator start-up count in cycles
`define BORS_STARTUP_CYC        1024
// Oscillator select codes
`define BORS_OSC_FRC            3'h0
`define BORS_OSC_FRC_PLL        3'h1
`define BORS_OSC_PRI            3'h2
`define BORS_OSC_PRI_PLL        3'h3
// Primary oscillator modes
`define BORS_POSC_EC            2'h0
`define BORS_POSC_XT            2'h1
`define BORS_POSC_HS            2'h2
`define BORS_POSC_OFF           2'h3
// Field positions
`define BORS_OSC_CTRL_LOCK_BIT  5
`define BORS_RST_CTRL_FLAG_BIT  1

`endif

/* logic/bors_delay_counter.v */
// Down counter used for each of the sequencer's delays.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/1ps

module bors_delay_counter #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // Control
  input  wire             load_i,
  input  wire [WIDTH-1:0] count_i,
  // Status
  output reg              done_o
);

  reg [WIDTH-1:0] cnt_reg;

  // Load, then count down to zero
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_reg <= {WIDTH{1'b0}};
      done_o  <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_reg <= count_i;
      done_o  <= 1'b0;
    end
    else if (cnt_reg != {WIDTH{1'b0}})
    begin
      cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      done_o  <= (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
    end
    else
    begin
      done_o  <= 1'b1;
    end
  end

endmodule

/* tb/bors_clkgen_model.sv */
// Clock generator model: PLL lock after a settling count.
// Assumes pll_sel_i and rst_i come from the sequencer.
`timescale 1ns/1ps
module bors_clkgen_model #(
  parameter [7:0] LOCK_CYC = 8'h28
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pll_sel_i,
  output reg  lock_o
);
  reg [7:0] cnt_reg = 8'h0;
  always @(posedge clk_i)
    if (rst_i || !pll_sel_i)
    begin
      cnt_reg <= 8'h0;
      lock_o  <= 1'b0;
    end
    else if (cnt_reg == LOCK_CYC)
      lock_o <= 1'b1;
    else
      cnt_reg <= cnt_reg + 8'h1;
endmodule

/* tb/bors_sequencer_props.sv */
// Checker on the sequencer ports.
// Assumes it is bound into every bors_sequencer.
`timescale 1ns/1ps
module bors_props #(
  parameter [31:0] PWRUP_CYC = 32'h14,
  parameter [31:0] FSCM_CYC  = 32'ha,
  parameter [31:0] STARTUP_CYC = 32'h8
) (
  input wire       clk_i,
  input wire       sys_rst_i,
  input wire       supply_drop_i,
  input wire       sleep_mode_i,
  input wire [2:0] osc_select_cfg_i,
  input wire [1:0] primary_osc_mode_cfg_i,
  input wire       pwrup_delay_en_i,
  input wire       flag_wr_i,
  input wire       device_rst_o,
  input wire       internal_rst_o,
  input wire       sysclk_en_o,
  input wire [2:0] clk_source_o,
  input wire       pll_sel_o,
  input wire [5:0] osc_control_reg_o,
  input wire [1:0] reset_control_reg_o
);
  reg  [31:0] cnt_reg;
  wire [1:0]  md   = primary_osc_mode_cfg_i;
  wire        prim = (osc_select_cfg_i[2:1] == 2'h1) && (md != 2'h3);
  wire        xtal = prim && (md != 2'h0);
  wire [31:0] pmin = pwrup_delay_en_i ? PWRUP_CYC : (xtal ? FSCM_CYC : 32'h0);
  // Cycles of internal reset after the pulse
  always @(posedge clk_i)
    if (sys_rst_i || device_rst_o)
      cnt_reg <= 32'h0;
    else if (internal_rst_o)
      cnt_reg <= cnt_reg + 32'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_pulse;
    $rose(supply_drop_i) |-> ##[1:4] device_rst_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("no reset pulse");
  property p_src;
    $fell(device_rst_o) |-> clk_source_o == osc_select_cfg_i
      && pll_sel_o == (osc_select_cfg_i[0] && !osc_select_cfg_i[2]);
  endproperty
  a_src: assert property (p_src) else $error("bad clock source");
  property p_ost;
    $fell(internal_rst_o) && prim |-> cnt_reg >= STARTUP_CYC;
  endproperty
  a_ost: assert property (p_ost) else $error("start-up too short");
  property p_gate;
    $fell(device_rst_o) |-> !sysclk_en_o;
  endproperty
  a_gate: assert property (p_gate) else $error("clock before start-up");
  property p_lock;
    internal_rst_o && pll_sel_o && !osc_control_reg_o[5] |-> !sysclk_en_o;
  endproperty
  a_lock: assert property (p_lock) else $error("clock before lock");
  property p_pwr;
    $fell(internal_rst_o) |-> cnt_reg >= pmin;
  endproperty
  a_pwr: assert property (p_pwr) else $error("delay too short");
  property p_flag;
    $rose(device_rst_o) |-> reset_control_reg_o[1];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_sleep;
    sleep_mode_i && $rose(supply_drop_i) |-> ##[1:4] device_rst_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no reset in sleep");
  property p_rel;
    $fell(internal_rst_o) |-> sysclk_en_o && !device_rst_o;
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_keep;
    reset_control_reg_o[1] && !flag_wr_i |=> reset_control_reg_o[1];
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  c_pll: cover property ($fell(internal_rst_o) && pll_sel_o);
  c_slp: cover property ($rose(device_rst_o) && sleep_mode_i);
  c_clr: cover property ($fell(reset_control_reg_o[1]));
endmodule
bind bors_sequencer bors_props #(
  .PWRUP_CYC(PWRUP_CYC), .FSCM_CYC(FSCM_CYC), .STARTUP_CYC(STARTUP_CYC)
) bors_props_inst (.clk_i, .sys_rst_i, .supply_drop_i, .sleep_mode_i, .osc_select_cfg_i,
  .primary_osc_mode_cfg_i, .pwrup_delay_en_i, .flag_wr_i, .device_rst_o, .internal_rst_o,
  .sysclk_en_o, .clk_source_o, .pll_sel_o, .osc_control_reg_o, .reset_control_reg_o);

/* tb/brownout_reset_sequencer_tb_top.sv */
// Bench for the supply-drop sequencer.
// Assumes the clock model supplies PLL lock.
`timescale 1ns/1ps
module brownout_reset_sequencer_tb_top;
  reg clk_i = 0, sys_rst_i = 1, drop = 0, lp = 0, pen = 1, fwr = 0, fwd = 0;
  reg [2:0] sel = 0;
  reg [1:0] mode = 3;
  reg [7:0] dmin;
  reg [19:0] rows [0:5];
  wire drst, irst, cen, psel, lock;
  wire [2:0] src;
  wire [5:0] ocr;
  wire [1:0] rcr;
  integer n_mismatch = 0, n_checks = 0, i, c, r;
  always #10 clk_i = ~clk_i;
  bors_sequencer #(.PWRUP_CYC(32'h14), .FSCM_CYC(32'ha), .STARTUP_CYC(32'h8))
    bors_sequencer_inst (
    .clk_i, .sys_rst_i, .supply_drop_i(drop), .sleep_mode_i(lp), .idle_mode_i(lp),
    .osc_select_cfg_i(sel), .primary_osc_mode_cfg_i(mode), .pwrup_delay_en_i(pen),
    .pll_lock_i(lock), .flag_wr_i(fwr), .flag_wdata_i(fwd), .device_rst_o(drst),
    .internal_rst_o(irst), .sysclk_en_o(cen), .clk_source_o(src), .pll_sel_o(psel),
    .osc_control_reg_o(ocr), .reset_control_reg_o(rcr));
  bors_clkgen_model bors_clkgen_model_inst (.clk_i, .rst_i(drst), .pll_sel_i(psel),
    .lock_o(lock));
  task conclude;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task tick;
  begin
    @(posedge clk_i);
    #1;
  end
  endtask
  // Waits out the pulse, then counts held cycles
  task wait_rel;
  begin
    c = 0;
    for (i = 0; i < 300 && drst !== 1'b0; i = i + 1)
      tick;
    for (c = 0; c < 300 && irst !== 1'b0; c = c + 1)
      tick;
    if (c >= 300 || i >= 300)
    begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  endtask
  task pulse;
  begin
    drop = 1;
    repeat (4) tick;
    chk(drst, 1);
    drop = 0;
  end
  endtask
  initial
  begin
    // Select, mode, delay enable, minimum delay
    rows[0] = 20'h03114;
    rows[1] = 20'h13128;
    rows[2] = 20'h2100a;
    rows[3] = 20'h32128;
    rows[4] = 20'h20008;
    rows[5] = 20'h2200a;
    repeat (20) tick;
    chk({drst, irst, cen, rcr}, 5'h18);
    sys_rst_i = 0;
    wait_rel;
    chk(rcr, 0);
    for (r = 0; r < 6; r = r + 1)
    begin
      {sel, mode, pen, dmin} = {rows[r][18:16], rows[r][13:12], rows[r][8], rows[r][7:0]};
      tick;
      pulse;
      wait_rel;
      chk(rcr, 2);
      chk({src, psel}, {sel, sel[0] & ~sel[2]});
      chk(c >= dmin, 1);
      chk({cen, ocr}, {1'b1, sel[0] & ~sel[2], 5'h0});
      fwr = 1;
      tick;
      fwr = 0;
      tick;
      chk(rcr, 0);
    end
    // Drop in low power, repeated mid-sequence
    lp = 1;
    pulse;
    repeat (12) tick;
    pulse;
    wait_rel;
    chk(c >= dmin, 1);
    chk(rcr, 2);
    {fwr, fwd} = 2'h3;
    tick;
    fwr = 0;
    tick;
    chk(rcr, 2);
    // Long drop keeps the pulse up
    drop = 1;
    repeat (30) tick;
    chk(drst, 1);
    drop = 0;
    wait_rel;
    chk(irst, 0);
    conclude;
  end
endmodule
